// ===== hdl/clock_supervisor_pkg.sv
// Shared constants and carrier types of the main clock stop supervisor.
package clock_supervisor_pkg;

  localparam logic [31:0] MODE_ADDR   = 32'hFFFFF870;
  localparam logic [31:0] CAUSE_ADDR  = 32'hFFFFF874;
  localparam logic [31:0] STATUS_ADDR = 32'hFFFFF878;
  localparam logic [31:0] MASK_ADDR   = 32'hFFFFF87C;
  localparam logic [31:0] GUARD_ADDR  = 32'hFFFFF880;

  localparam int ENABLE_BIT = 0;
  localparam int CAUSE_BIT  = 0;
  localparam int EV_STOP    = 0;
  localparam int EV_ARMED   = 1;

  localparam logic [7:0] MODE_RESET   = 8'h00;
  localparam logic [1:0] STATUS_RESET = 2'h0;
  localparam logic [1:0] MASK_RESET   = 2'h0;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam int CLK_PERIOD_NS  = 10;
  localparam int STALL_PERIODS  = 4;
  localparam int HOLD_TIME_NS   = 160;
  localparam int HOLD_CYCLES    =
    (HOLD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    SUP_IDLE  = 2'h0,
    SUP_WATCH = 2'h1,
    SUP_HOLD  = 2'h3
  } sup_state_t;

  // Power and clock status from the clock generator, same clock domain.
  typedef struct packed {
    logic stop_mode;
    logic osc_settling;
    logic main_osc_halt;
    logic clock_select_status;
    logic internal_osc_stop;
    logic cpu_on_internal_osc_flag;
  } power_status_t;

endpackage

// ===== hdl/main_clk_edge_detect.sv
// Synchroniser and toggle edge detector for the main clock pin.
`timescale 1ns/1ns
module main_clk_edge_detect (
  // Clock and reset
  input  wire logic mclk_in,
  input  wire logic rst_in,
  // Main clock pin
  input  wire logic main_clk_in,
  // One-cycle pulse per observed main clock transition
  output logic      edge_out
);

  typedef struct packed {
    logic meta;
    logic sync;
    logic last;
    logic edge_seen;
  } det_t;

  det_t det_reg;
  det_t det_next;

  // Any transition of the synchronised level counts as activity.
  always_comb begin
    det_next           = det_reg;
    det_next.meta      = main_clk_in;
    det_next.sync      = det_reg.meta;
    det_next.last      = det_reg.sync;
    det_next.edge_seen = det_reg.sync ^ det_reg.last;
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      det_reg <= '0;
    end else begin
      det_reg <= det_next;
    end
  end

  assign edge_out = det_reg.edge_seen;

endmodule

// ===== hdl/main_clock_stop_supervisor.sv
// Main clock stop supervisor with its AXI4-Lite register slave.
//
// Notes on behaviour
// - The mode register only takes writes made through the guarded sequence.
// - The mode register is accessible as a byte or single bit.
// - Any reset clears the mode register, so monitoring starts disabled.
// - Bit 0 enables monitoring; writing 1 starts it; bits 7 to 1 read 0.
// - Once set, the enable ignores software writes of 0; only reset clears.
// - A supervisor reset clears the enable and sets the cause flag.
// - A supervisor reset leaves other reset cause flags untouched.
// - Enabled and active, a stopped main clock asserts the system reset.
// - Pin reset clears the enable; software re-enables after settling.
// - Monitoring pauses in STOP and settling and resumes by itself.
// - Main oscillator halt pauses monitoring until main clock reselected.
// - Monitoring pauses while the sampling oscillator is stopped.
// - Monitoring pauses while the CPU runs from the internal oscillator.
// - Monitoring continues in HALT, IDLE and sub-IDLE with main clock.
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ns
module main_clock_stop_supervisor (
  // Clock and reset
  input  wire logic                          mclk_in,
  input  wire logic                          rst_in,
  input  wire logic                          int_reset_in,
  // Monitored clock and chip status
  input  wire logic                          main_clk_in,
  input  wire clock_supervisor_pkg::power_status_t power_in,
  // Chip reset, monitoring state and interrupt
  output logic                               sys_reset_req_out,
  output logic                               monitoring_out,
  output logic                               irq_out,
  // AXI4-Lite write address and data
  input  wire logic [31:0]                   s_axi_awaddr,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [31:0]                   s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                         s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  // AXI4-Lite read
  input  wire logic [31:0]                   s_axi_araddr,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  output logic [31:0]                        s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready
);

  typedef struct packed {
    clock_supervisor_pkg::sup_state_t state;
    logic [2:0]  stall_cnt;
    logic [4:0]  hold_cnt;
    logic        enable;
    logic        cause_flag;
    logic        halt_pause;
    logic        guard_armed;
    logic [1:0]  status;
    logic [1:0]  mask;
    logic        irq;
    logic        sys_reset;
    logic        monitoring;
    logic        aw_have;
    logic [31:0] aw_addr;
    logic        w_have;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } sup_t;

  localparam logic [2:0] STALL_LAST =
    3'(clock_supervisor_pkg::STALL_PERIODS - 1);
  localparam logic [4:0] HOLD_LAST =
    5'(clock_supervisor_pkg::HOLD_CYCLES - 1);

  sup_t r_reg;
  sup_t r_next;
  logic main_edge;

  main_clk_edge_detect u_edge (
    .mclk_in     (mclk_in),
    .rst_in      (rst_in),
    .main_clk_in (main_clk_in),
    .edge_out    (main_edge)
  );

  always_comb begin
    logic        active;
    logic        do_write;
    logic        do_read;
    logic        hit;
    logic        stop_ev;
    logic        arm_ev;
    logic        status_rd;
    logic [31:0] rd;
    active    = 1'b0;
    do_write  = 1'b0;
    do_read   = 1'b0;
    hit       = 1'b0;
    stop_ev   = 1'b0;
    arm_ev    = 1'b0;
    status_rd = 1'b0;
    rd        = 32'h0000_0000;
    r_next    = r_reg;

    // Halt of the main oscillator pauses until the main clock is
    // selected again; leaving subclock operation ends the pause.
    r_next.halt_pause = power_in.clock_select_status &
      (r_reg.halt_pause | power_in.main_osc_halt);

    active = r_reg.enable
           & ~power_in.stop_mode & ~power_in.osc_settling
           & ~r_reg.halt_pause
           & ~power_in.internal_osc_stop
           & ~power_in.cpu_on_internal_osc_flag;

    // Write address and data are taken in either order.
    if (s_axi_awvalid && r_reg.awready) begin
      r_next.aw_have = 1'b1;
      r_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && r_reg.wready) begin
      r_next.w_have = 1'b1;
      r_next.w_data = s_axi_wdata;
      r_next.w_strb = s_axi_wstrb;
    end
    if (r_reg.bvalid && s_axi_bready) begin
      r_next.bvalid = 1'b0;
    end
    do_write = r_reg.aw_have && r_reg.w_have && !r_reg.bvalid;

    if (do_write) begin
      r_next.aw_have     = 1'b0;
      r_next.w_have      = 1'b0;
      r_next.bvalid      = 1'b1;
      r_next.bresp       = clock_supervisor_pkg::RESP_OKAY;
      r_next.guard_armed = 1'b0;
      hit = 1'b1;
      unique case (r_reg.aw_addr)
        clock_supervisor_pkg::MODE_ADDR: begin
          if (r_reg.guard_armed && r_reg.w_strb[0] &&
              r_reg.w_data[clock_supervisor_pkg::ENABLE_BIT]) begin
            if (!r_reg.enable) begin
              arm_ev = 1'b1;
            end
            r_next.enable = 1'b1;
          end
        end
        clock_supervisor_pkg::CAUSE_ADDR: begin
          if (r_reg.w_strb[0] &&
              !r_reg.w_data[clock_supervisor_pkg::CAUSE_BIT]) begin
            r_next.cause_flag = 1'b0;
          end
        end
        clock_supervisor_pkg::MASK_ADDR: begin
          if (r_reg.w_strb[0]) begin
            r_next.mask = r_reg.w_data[1:0];
          end
        end
        clock_supervisor_pkg::GUARD_ADDR: begin
          r_next.guard_armed = 1'b1;
        end
        default: begin
          hit          = 1'b0;
          r_next.bresp = clock_supervisor_pkg::RESP_SLVERR;
        end
      endcase
    end

    // Reads answer one cycle after the address is taken.
    if (r_reg.rvalid && s_axi_rready) begin
      r_next.rvalid = 1'b0;
    end
    do_read = s_axi_arvalid && r_reg.arready;
    if (do_read) begin
      r_next.rvalid = 1'b1;
      r_next.rresp  = clock_supervisor_pkg::RESP_OKAY;
      unique case (s_axi_araddr)
        clock_supervisor_pkg::MODE_ADDR: begin
          rd[0] = r_reg.enable;
        end
        clock_supervisor_pkg::CAUSE_ADDR: begin
          rd[0] = r_reg.cause_flag;
        end
        clock_supervisor_pkg::STATUS_ADDR: begin
          rd[1:0]   = r_reg.status;
          status_rd = 1'b1;
        end
        clock_supervisor_pkg::MASK_ADDR: begin
          rd[1:0] = r_reg.mask;
        end
        clock_supervisor_pkg::GUARD_ADDR: begin
          rd = 32'h0000_0000;
        end
        default: begin
          r_next.rresp = clock_supervisor_pkg::RESP_SLVERR;
        end
      endcase
      r_next.rdata = rd;
    end

    // Stop detector and reset hold.
    r_next.sys_reset = 1'b0;
    unique case (r_reg.state)
      clock_supervisor_pkg::SUP_IDLE: begin
        r_next.stall_cnt = 3'h0;
        if (active) begin
          r_next.state = clock_supervisor_pkg::SUP_WATCH;
        end
      end
      clock_supervisor_pkg::SUP_WATCH: begin
        if (!active) begin
          r_next.state = clock_supervisor_pkg::SUP_IDLE;
        end else if (main_edge) begin
          r_next.stall_cnt = 3'h0;
        end else if (r_reg.stall_cnt == STALL_LAST) begin
          r_next.state      = clock_supervisor_pkg::SUP_HOLD;
          r_next.hold_cnt   = 5'h00;
          r_next.sys_reset  = 1'b1;
          r_next.cause_flag = 1'b1;
          stop_ev           = 1'b1;
        end else begin
          r_next.stall_cnt = r_reg.stall_cnt + 3'h1;
        end
      end
      clock_supervisor_pkg::SUP_HOLD: begin
        r_next.enable = 1'b0;
        if (r_reg.hold_cnt == HOLD_LAST) begin
          r_next.state = clock_supervisor_pkg::SUP_IDLE;
        end else begin
          r_next.hold_cnt  = r_reg.hold_cnt + 5'h01;
          r_next.sys_reset = 1'b1;
        end
      end
      default: begin
        r_next.state = clock_supervisor_pkg::SUP_IDLE;
      end
    endcase
    if (stop_ev) begin
      r_next.enable = 1'b0;
    end
    r_next.monitoring =
      (r_next.state == clock_supervisor_pkg::SUP_WATCH);

    // Events set status bits; a read clears them, a new event wins.
    r_next.status = (status_rd ? 2'h0 : r_reg.status)
                  | {arm_ev, stop_ev};
    r_next.irq = |(r_next.status & r_next.mask);

    r_next.awready = !r_next.aw_have && !r_next.bvalid;
    r_next.wready  = !r_next.w_have && !r_next.bvalid;
    r_next.arready = !r_next.rvalid;

    // Another internal reset clears the mode register but keeps the cause.
    if (int_reset_in) begin
      r_next.enable      = clock_supervisor_pkg::MODE_RESET[0];
      r_next.guard_armed = 1'b0;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      r_reg         <= '0;
      r_reg.state   <= clock_supervisor_pkg::SUP_IDLE;
      r_reg.enable  <= clock_supervisor_pkg::MODE_RESET[0];
      r_reg.status  <= clock_supervisor_pkg::STATUS_RESET;
      r_reg.mask    <= clock_supervisor_pkg::MASK_RESET;
      r_reg.awready <= 1'b1;
      r_reg.wready  <= 1'b1;
      r_reg.arready <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  assign sys_reset_req_out = r_reg.sys_reset;
  assign monitoring_out    = r_reg.monitoring;
  assign irq_out           = r_reg.irq;
  assign s_axi_awready     = r_reg.awready;
  assign s_axi_wready      = r_reg.wready;
  assign s_axi_bvalid      = r_reg.bvalid;
  assign s_axi_bresp       = r_reg.bresp;
  assign s_axi_arready     = r_reg.arready;
  assign s_axi_rvalid      = r_reg.rvalid;
  assign s_axi_rdata       = r_reg.rdata;
  assign s_axi_rresp       = r_reg.rresp;

endmodule

// ===== tb/main_clock_stop_supervisor_asserts.sv
// Concurrent checks on the supervisor's top-level ports.
`timescale 1ns/1ns
module main_clock_stop_supervisor_asserts (
  // Clock and reset
  input wire logic                              mclk_in,
  input wire logic                              rst_in,
  // Chip status and supervisor outputs
  input wire clock_supervisor_pkg::power_status_t power_in,
  input wire logic                              sys_reset_req_out,
  input wire logic                              monitoring_out,
  input wire logic                              irq_out,
  // Bus handshakes
  input wire logic                              s_axi_arvalid,
  input wire logic                              s_axi_arready,
  input wire logic                              s_axi_rvalid,
  input wire logic                              s_axi_bvalid,
  input wire logic                              s_axi_bready
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in);

  // Two sampled cycles of a pause source leave the detector idle.
  property p_pause(c);
    c [*2] |=> !monitoring_out;
  endproperty

  a_pause_stop: assert property (p_pause(power_in.stop_mode))
    else $error("monitoring while in stop mode");
  a_pause_settle: assert property (p_pause(power_in.osc_settling))
    else $error("monitoring while oscillator settles");
  a_pause_rc_stop: assert property (p_pause(power_in.internal_osc_stop))
    else $error("monitoring while sampling clock is stopped");
  a_pause_cpu_int: assert property
    (p_pause(power_in.cpu_on_internal_osc_flag))
    else $error("monitoring while cpu runs on internal clock");
  a_hold_len: assert property ($rose(sys_reset_req_out) |->
    sys_reset_req_out [*8] ##1 sys_reset_req_out [*8] ##1 !sys_reset_req_out)
    else $error("reset request length wrong");
  a_req_from_watch: assert property ($rose(sys_reset_req_out) |->
    $past(monitoring_out)) else $error("reset request without monitoring");
  a_hold_quiet: assert property ($rose(sys_reset_req_out) |->
    ##2 !monitoring_out [*8]) else $error("monitoring during reset hold");
  a_reset_quiet: assert property ($fell(rst_in) |->
    !sys_reset_req_out && !monitoring_out && !irq_out)
    else $error("outputs active after reset");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read data late");
  a_one_resp: assert property (s_axi_bvalid && s_axi_bready |=>
    !s_axi_bvalid) else $error("write response repeated");

  cover property ($rose(sys_reset_req_out));
  cover property ($rose(monitoring_out));
  cover property ($rose(irq_out));
endmodule

// ===== tb/main_osc_model.sv
// Behavioural main oscillator and chip reset logic facing the supervisor.
`timescale 1ns/1ns
module main_osc_model #(
  parameter int HALF_NS = 16
) (
  // Bench controls
  input  wire logic run_in,
  input  wire logic wdt_in,
  // Supervisor reset request
  input  wire logic req_in,
  // To the supervisor
  output logic      clk_out,
  output logic      int_reset_out
);
  // A stopped crystal holds its last level.
  initial clk_out = 1'b0;
  always #HALF_NS if (run_in) clk_out = ~clk_out;

  // Other internal resets reach the supervisor without touching the cause.
  assign int_reset_out = req_in | wdt_in;
endmodule

// ===== tb/tb_main_clock_stop_supervisor.sv
// Self-checking bench for the main clock stop supervisor.
`timescale 1ns/1ns
module tb_main_clock_stop_supervisor;
  logic mclk_in, rst_in, int_reset_in, main_clk_in, run, wdt;
  clock_supervisor_pkg::power_status_t power_in;
  logic sys_reset_req_out, monitoring_out, irq_out;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rv;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [5:0] pv [4];
  int fail_count, checked, n;
  int cyc = 0;

  main_clock_stop_supervisor uut (.mclk_in, .rst_in, .int_reset_in,
    .main_clk_in, .power_in, .sys_reset_req_out, .monitoring_out, .irq_out,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  main_osc_model osc (.run_in(run), .wdt_in(wdt), .req_in(sys_reset_req_out),
    .clk_out(main_clk_in), .int_reset_out(int_reset_in));

  initial begin
    mclk_in = 1'b0;
    forever #5 mclk_in = ~mclk_in;
  end

  task chk(input logic [31:0] s, e);
    checked++;
    if (s !== e) begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  task wr(input logic [31:0] a, d);
    logic ad, wd;
    begin
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      ad = 1'b0;
      wd = 1'b0;
      while (!(ad && wd)) begin
        @(posedge mclk_in);
        if (s_axi_awready && !ad) begin
          ad = 1'b1;
          s_axi_awvalid <= 1'b0;
        end
        if (s_axi_wready && !wd) begin
          wd = 1'b1;
          s_axi_wvalid <= 1'b0;
        end
      end
      s_axi_bready <= 1'b1;
      do @(posedge mclk_in); while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      resp = s_axi_bresp;
    end
  endtask

  task rd(input logic [31:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge mclk_in); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(posedge mclk_in); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    rv = s_axi_rdata;
    resp = s_axi_rresp;
  endtask

  task rc(input logic [31:0] a, e);
    rd(a);
    chk(rv, e);
  endtask

  task wg(input logic [31:0] d);
    wr(clock_supervisor_pkg::GUARD_ADDR, 32'h0);
    wr(clock_supervisor_pkg::MODE_ADDR, d);
  endtask

  task stop_test;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  always @(posedge mclk_in) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fail_count++;
      stop_test;
    end
  end

  initial begin
    {rst_in, run, wdt, power_in, s_axi_wstrb} = {3'b110, 6'h00, 4'h1};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
    {fail_count, checked} = 64'h0;
    pv = '{6'h20, 6'h10, 6'h02, 6'h01};
    repeat (6) @(posedge mclk_in);
    rst_in <= 1'b0;
    rc(clock_supervisor_pkg::MODE_ADDR, 32'h0);
    rd(32'hFFFFF890);
    chk(resp, clock_supervisor_pkg::RESP_SLVERR);
    wr(clock_supervisor_pkg::MODE_ADDR, 32'h1);
    chk(resp, clock_supervisor_pkg::RESP_OKAY);
    rc(clock_supervisor_pkg::MODE_ADDR, 32'h0);
    wr(clock_supervisor_pkg::GUARD_ADDR, 32'h0);
    wr(clock_supervisor_pkg::MASK_ADDR, 32'h3);
    wr(clock_supervisor_pkg::MODE_ADDR, 32'h1);
    rc(clock_supervisor_pkg::MODE_ADDR, 32'h0);
    wr(clock_supervisor_pkg::MASK_ADDR, 32'h3);
    wg(32'hFF);
    rc(clock_supervisor_pkg::MODE_ADDR, 32'h1);
    chk(irq_out, 1'b1);
    rc(clock_supervisor_pkg::STATUS_ADDR, 32'h2);
    repeat (2) @(posedge mclk_in);
    chk(irq_out, 1'b0);
    wg(32'h0);
    rc(clock_supervisor_pkg::MODE_ADDR, 32'h1);
    chk(monitoring_out, 1'b1);
    for (int i = 0; i < 4; i++) begin
      power_in <= pv[i];
      repeat (3) @(posedge mclk_in);
      run <= 1'b0;
      repeat (12) @(posedge mclk_in);
      chk({monitoring_out, sys_reset_req_out}, 2'b00);
      run <= 1'b1;
      repeat (10) @(posedge mclk_in);
      power_in <= 6'h00;
      repeat (4) @(posedge mclk_in);
      chk(monitoring_out, 1'b1);
    end
    power_in <= 6'h0C;
    repeat (3) @(posedge mclk_in);
    run <= 1'b0;
    repeat (12) @(posedge mclk_in);
    power_in <= 6'h04;
    run <= 1'b1;
    repeat (10) @(posedge mclk_in);
    chk({monitoring_out, sys_reset_req_out}, 2'b00);
    power_in <= 6'h00;
    repeat (4) @(posedge mclk_in);
    chk(monitoring_out, 1'b1);
    power_in <= 6'h04;
    wr(clock_supervisor_pkg::MASK_ADDR, 32'h0);
    chk(monitoring_out, 1'b1);
    run <= 1'b0;
    do @(posedge mclk_in); while (!sys_reset_req_out);
    n = 0;
    while (sys_reset_req_out) begin
      n++;
      @(posedge mclk_in);
    end
    chk(n, clock_supervisor_pkg::HOLD_CYCLES);
    chk(irq_out, 1'b0);
    rc(clock_supervisor_pkg::MODE_ADDR, 32'h0);
    rc(clock_supervisor_pkg::CAUSE_ADDR, 32'h1);
    wr(clock_supervisor_pkg::MASK_ADDR, 32'h3);
    repeat (2) @(posedge mclk_in);
    chk(irq_out, 1'b1);
    rc(clock_supervisor_pkg::STATUS_ADDR, 32'h1);
    run <= 1'b1;
    power_in <= 6'h00;
    wg(32'h1);
    wdt <= 1'b1;
    @(posedge mclk_in);
    wdt <= 1'b0;
    rc(clock_supervisor_pkg::MODE_ADDR, 32'h0);
    rc(clock_supervisor_pkg::CAUSE_ADDR, 32'h1);
    rst_in <= 1'b1;
    repeat (2) @(posedge mclk_in);
    rst_in <= 1'b0;
    rc(clock_supervisor_pkg::CAUSE_ADDR, 32'h0);
    rc(clock_supervisor_pkg::MODE_ADDR, 32'h0);
    wg(32'h1);
    repeat (4) @(posedge mclk_in);
    chk(monitoring_out, 1'b1);
    stop_test;
  end
endmodule

bind main_clock_stop_supervisor main_clock_stop_supervisor_asserts sva (
  .mclk_in, .rst_in, .power_in, .sys_reset_req_out, .monitoring_out,
  .irq_out, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_bvalid,
  .s_axi_bready);
